// [rtl/count_slice.sv]
// One 16-bit timer word with its prescaler
`timescale 1ns/1ps
module count_slice #(
  parameter int W = paired_timer_pkg::CNT_W
) (
  // Clock, reset, enable
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   ce,
  // Count source and control
  input  wire logic                   run,
  input  wire logic                   ev,
  input  wire paired_timer_pkg::psc_e psc,
  input  wire logic                   inc,
  input  wire logic                   clr,
  // Results
  output logic                        tick,
  output logic [W-1:0]                cnt
);

  typedef struct packed {
    logic [7:0]   pcnt;
    logic [W-1:0] cnt;
  } slice_state_s;

  slice_state_s st_q;
  slice_state_s st_d;
  logic [7:0]   tc;

  // Refuse widths the carry logic cannot serve
  if (W < 2)
  begin : g_bad_w
    $error("count_slice: W must be at least 2");
  end

  // Prescaler terminal count
  always_comb
  begin
    case (psc)
      paired_timer_pkg::PSC_1:   tc = paired_timer_pkg::PSC_TC_1;
      paired_timer_pkg::PSC_8:   tc = paired_timer_pkg::PSC_TC_8;
      paired_timer_pkg::PSC_64:  tc = paired_timer_pkg::PSC_TC_64;
      paired_timer_pkg::PSC_256: tc = paired_timer_pkg::PSC_TC_256;
      default:                   tc = paired_timer_pkg::PSC_TC_1;
    endcase
  end

  assign tick = run & ev & (st_q.pcnt == tc);
  assign cnt  = st_q.cnt;

  // Next state: prescaler divides events, word steps on request
  always_comb
  begin
    st_d = st_q;
    if (!run)
      st_d.pcnt = paired_timer_pkg::PSC_RST;
    else if (ev)
      st_d.pcnt = tick ? paired_timer_pkg::PSC_RST : st_q.pcnt + 8'h01;
    if (clr)
      st_d.cnt = '0;
    else if (inc)
      st_d.cnt = st_q.cnt + {{(W-1){1'b0}}, 1'b1};
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk)
  begin
    if (srst)
      st_q <= '0;
    else if (ce)
      st_q <= st_d;
  end

endmodule : count_slice

// [rtl/paired_timer.sv]
// Two pairs of 16-bit timers, each pair joinable into one 32-bit timer
// Contract
// [R1] Two pairs; each pair is one 32-bit timer or two 16-bit timers.
// [R2] Split halves offer all 16-bit modes except asynchronous counting.
// [R3] Each 16-bit timer counts the clock or synchronised external events.
// [R4] In 32-bit mode even timers hold the low word, odd the high word.
// [R5] In 32-bit mode odd control bits are ignored; even control rules.
// [R6] In 32-bit mode only the even timer's clock and gate pins act.
// [R7] A 32-bit pair signals when its count matches the 32-bit period.
// [R8] A 32-bit pair's event goes to the odd timer's flag only.
// [R9] Only timers two and three feed capture and compare time bases.
// [R10] Converter trigger comes from the second/third timer pair only.
// [R11] Each of the four timers can raise a DMA trigger.
// [R12] Timers keep counting in Idle and Sleep when configured to.
// [R13] In 32-bit mode low-word rollover carries into high word same step.
// [R14] On match the count clears next step; flag stays until cleared.
`timescale 1ns/1ps
module paired_timer #(
  parameter int W = paired_timer_pkg::CNT_W
) (
  // Clock, reset, enable
  input  wire logic                                clk,
  input  wire logic                                srst,
  input  wire logic                                ce,
  // Power modes
  input  wire logic                                idle,
  input  wire logic                                sleep,
  // Configuration per timer
  input  wire paired_timer_pkg::tmr_ctrl_s [3:0]   ctrl,
  input  wire logic [3:0][W-1:0]                   period,
  input  wire logic [3:0]                          flag_clr,
  // Pins
  input  wire logic [3:0]                          ext_clk_pin,
  input  wire logic [3:0]                          gate_pin,
  // Counts and events
  output logic [3:0][W-1:0]                        cnt_o,
  output logic [3:0]                               flag_o,
  output logic [3:0]                               dma_trig,
  output logic                                     adc_trig,
  output logic [1:0][W-1:0]                        tb_cnt,
  output logic [1:0]                               tb_match
);

  paired_timer_pkg::timer_top_s       st_q;
  paired_timer_pkg::timer_top_s       st_d;
  paired_timer_pkg::tmr_ctrl_s [3:0]  ectl;
  logic [3:0]                         run;
  logic [3:0]                         ev;
  logic [3:0]                         inc;
  logic [3:0]                         clr;
  logic [3:0]                         evt;
  logic [3:0]                         fset;
  logic [3:0]                         tick;
  logic [3:0]                         paired;
  logic [3:0]                         m16;
  logic [1:0]                         m32;
  logic [3:0]                         ext_rise;
  logic [3:0]                         gate_fall;
  logic [3:0]                         ext_lvl_d;
  logic [3:0]                         gat_lvl_d;
  logic [3:0][W-1:0]                  cnt;

  // Refuse widths the pairing logic cannot serve
  if (W < 2)
  begin : g_bad_w
    $error("paired_timer: W must be at least 2");
  end

  // Agreed pin levels: change taken once stages two and three match
  assign ext_lvl_d = (st_q.ext.st3 & ~(st_q.ext.st2 ^ st_q.ext.st3))
                   | (st_q.ext.lvl & (st_q.ext.st2 ^ st_q.ext.st3));
  assign gat_lvl_d = (st_q.gat.st3 & ~(st_q.gat.st2 ^ st_q.gat.st3))
                   | (st_q.gat.lvl & (st_q.gat.st2 ^ st_q.gat.st3));
  assign ext_rise  = ext_lvl_d & ~st_q.ext.lvl;
  assign gate_fall = ~gat_lvl_d & st_q.gat.lvl;

  // Period compares, 16-bit per timer and 32-bit per pair
  assign m16[0] = cnt[0] == period[0];
  assign m16[1] = cnt[1] == period[1];
  assign m16[2] = cnt[2] == period[2];
  assign m16[3] = cnt[3] == period[3];
  assign m32[0] = {cnt[1], cnt[0]} == {period[1], period[0]}; // [R7] [R4]
  assign m32[1] = {cnt[3], cnt[2]} == {period[3], period[2]}; // [R7] [R4]

  // Per-timer control, sources and count steps
  always_comb
  begin
    ectl   = ctrl;
    run    = '0;
    ev     = '0;
    inc    = '0;
    clr    = '0;
    evt    = '0;
    fset   = '0;
    paired = '0;
    for (int i = 0; i < 4; i++)
    begin
      paired[i] = ctrl[i & 2].t32; // [R1]
      if (paired[i])
        ectl[i] = ctrl[i & 2]; // [R5]
      run[i] = ectl[i].on & ~(idle & ectl[i].stop_idle)
             & ~(sleep & ~ectl[i].run_sleep); // [R12]
      // Synchronous sources only; external events come through the synchroniser
      if (ectl[i].gate)
        ev[i] = st_q.gat.lvl[i & (paired[i] ? 2 : 3)]; // [R6]
      else if (ectl[i].ext_src)
        ev[i] = ext_rise[i & (paired[i] ? 2 : 3)]; // [R3] [R2] [R6]
      else
        ev[i] = 1'b1; // [R3]
      if (paired[i] && (i % 2 == 1))
        ev[i] = 1'b0; // [R6]
    end
    for (int i = 0; i < 4; i++)
    begin
      if (!paired[i])
      begin
        inc[i]  = tick[i] & ~m16[i];
        clr[i]  = tick[i] & m16[i]; // [R14]
        evt[i]  = tick[i] & m16[i];
        fset[i] = evt[i] | (ectl[i].gate & gate_fall[i]);
      end
      else if (i % 2 == 0)
      begin
        inc[i] = tick[i] & ~m32[i / 2]; // [R4]
        clr[i] = tick[i] & m32[i / 2]; // [R14]
      end
      else
      begin
        inc[i]  = tick[i & 2] & (cnt[i & 2] == {W{1'b1}}) & ~m32[i / 2]; // [R13]
        clr[i]  = tick[i & 2] & m32[i / 2]; // [R7] [R14]
        evt[i]  = tick[i & 2] & m32[i / 2]; // [R8]
        fset[i] = evt[i] | (ectl[i].gate & gate_fall[i & 2]); // [R8] [R6]
      end
    end
  end

  // Timer words
  for (genvar g = 0; g < 4; g++)
  begin : g_slice
    count_slice #(
      .W    (W)
    ) u_slice (
      .clk  (clk),
      .srst (srst),
      .ce   (ce),
      .run  (run[g]),
      .ev   (ev[g]),
      .psc  (ectl[g].psc),
      .inc  (inc[g]),
      .clr  (clr[g]),
      .tick (tick[g]),
      .cnt  (cnt[g])
    );
  end

  // Next state: synchronisers, sticky flags, trigger pulses
  always_comb
  begin
    st_d         = st_q;
    st_d.ext.st1 = ext_clk_pin;
    st_d.ext.st2 = st_q.ext.st1;
    st_d.ext.st3 = st_q.ext.st2;
    st_d.ext.lvl = ext_lvl_d;
    st_d.gat.st1 = gate_pin;
    st_d.gat.st2 = st_q.gat.st1;
    st_d.gat.st3 = st_q.gat.st2;
    st_d.gat.lvl = gat_lvl_d;
    st_d.flag    = fset | (st_q.flag & ~flag_clr); // [R14]
    st_d.dma     = evt; // [R11]
    st_d.adc     = evt[paired_timer_pkg::ADC_IDX]; // [R10]
    st_d.tbm     = {evt[paired_timer_pkg::TB_HI_IDX], evt[paired_timer_pkg::TB_LO_IDX]}; // [R9]
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q      <= '0;
      st_q.flag <= paired_timer_pkg::FLAG_RST;
      st_q.ext  <= '{st1: paired_timer_pkg::SYNC_RST, st2: paired_timer_pkg::SYNC_RST,
                     st3: paired_timer_pkg::SYNC_RST, lvl: paired_timer_pkg::SYNC_RST};
    end
    else if (ce)
      st_q <= st_d;
  end

  // Outputs
  assign cnt_o     = cnt;
  assign flag_o    = st_q.flag;
  assign dma_trig  = st_q.dma;
  assign adc_trig  = st_q.adc;
  assign tb_cnt    = {cnt[paired_timer_pkg::TB_HI_IDX], cnt[paired_timer_pkg::TB_LO_IDX]};
  assign tb_match  = st_q.tbm;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  flag_set_a: assert property (ce && fset[1] |=> flag_o[1]) // [R14]
    else $error("flag not set after event");
  flag_hold_a: assert property (flag_o[3] && !flag_clr[3] |=> flag_o[3]) // [R14]
    else $error("flag dropped without clear");
  even_silent_a: assert property (ctrl[0].t32 |-> !evt[0] && !dma_trig[0] ##1 1) // [R8]
    else $error("even timer event in 32-bit mode");
  carry_a: assert property (ce && ctrl[0].t32 && tick[0] && !m32[0] // [R13]
                            && cnt[0] == {W{1'b1}}
                            |=> cnt[1] == $past(cnt[1]) + 1'b1 && cnt[0] == '0)
    else $error("missing carry into high word");
  wrap32_a: assert property (ce && ctrl[2].t32 && tick[2] && m32[1] // [R7]
                             |=> cnt[2] == '0 && cnt[3] == '0 && flag_o[3] && dma_trig[3])
    else $error("32-bit wrap wrong");
  odd_follow_a: assert property (ctrl[0].t32 |-> run[1] == run[0] && !ev[1]) // [R5]
    else $error("odd control not ignored");
  adc_src_a: assert property (ce |=> adc_trig == $past(evt[1])) // [R10]
    else $error("converter trigger from wrong timer");
  dma_a: assert property (ce |=> dma_trig == $past(evt)) // [R11]
    else $error("dma trigger missing");
  idle_hold_a: assert property (ce && idle && ctrl[2].stop_idle // [R12]
                                |=> cnt[2] == $past(cnt[2]))
    else $error("count moved in idle");
  freeze_a: assert property (!ce |=> $stable(flag_o) && $stable(cnt_o))
    else $error("state moved with ce low");
  ext_sync_a: assert property (ce && !ctrl[0].t32 && ctrl[0].ext_src && !ctrl[0].gate // [R3]
                               && !ext_rise[0] |-> !ev[0])
    else $error("external count without synchronised edge");

  wrap32_c: cover property (ce && ctrl[0].t32 && evt[1]);
  wrap16_c: cover property (ce && !ctrl[2].t32 && evt[3]);
  gate_c: cover property (ce && fset[3] && !evt[3]);
  clear_race_c: cover property (ce && fset[1] && flag_clr[1]);

endmodule : paired_timer

// [rtl/paired_timer_pkg.sv]
// Shared constants and carriers for the paired timer block
package paired_timer_pkg;

  // Word width of one timer and number of timers
  localparam int CNT_W   = 16;
  localparam int NUM_TMR = 4;

  // Timer indices that feed the capture/compare time bases and the converter trigger
  localparam int TB_LO_IDX = 0;
  localparam int TB_HI_IDX = 1;
  localparam int ADC_IDX   = 1;

  // Prescaler terminal counts (ratio minus one)
  localparam logic [7:0] PSC_TC_1   = 8'h00;
  localparam logic [7:0] PSC_TC_8   = 8'h07;
  localparam logic [7:0] PSC_TC_64  = 8'h3F;
  localparam logic [7:0] PSC_TC_256 = 8'hFF;

  // Values after reset
  localparam logic [7:0] PSC_RST  = 8'h00;
  localparam logic [3:0] FLAG_RST = 4'h0;
  localparam logic [3:0] SYNC_RST = 4'h0;

  // Prescaler ratio select
  typedef enum logic [1:0] {
    PSC_1   = 2'b00,
    PSC_8   = 2'b01,
    PSC_64  = 2'b10,
    PSC_256 = 2'b11
  } psc_e;

  // Control bits of one timer
  typedef struct packed {
    logic on;
    logic t32;
    logic gate;
    logic ext_src;
    logic stop_idle;
    logic run_sleep;
    psc_e psc;
  } tmr_ctrl_s;

  // Three-stage pin synchroniser with agreed level
  typedef struct packed {
    logic [3:0] st1;
    logic [3:0] st2;
    logic [3:0] st3;
    logic [3:0] lvl;
  } pin_sync_s;

  // Whole state of the top module
  typedef struct packed {
    pin_sync_s  ext;
    pin_sync_s  gat;
    logic [3:0] flag;
    logic [3:0] dma;
    logic       adc;
    logic [1:0] tbm;
  } timer_top_s;

endpackage : paired_timer_pkg

// [verification/paired_timer_test.sv]
// Self-checking bench for the paired timer block
`timescale 1ns/1ps
module paired_timer_test;
  `define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

  // Stimulus and observed signals
  logic                             clk;
  logic                             srst;
  logic                             ce;
  logic                             idle;
  logic                             sleep;
  paired_timer_pkg::tmr_ctrl_s [3:0] ctrl;
  logic [3:0][15:0]                 period;
  logic [3:0]                       flag_clr;
  logic [3:0]                       ext_clk_pin;
  logic [3:0]                       gate_pin;
  logic [3:0][15:0]                 cnt_o;
  logic [3:0]                       flag_o;
  logic [3:0]                       dma_trig;
  logic                             adc_trig;
  logic [1:0][15:0]                 tb_cnt;
  logic [1:0]                       tb_match;
  logic [4:0]                       notes[$];
  logic [4:0]                       exp_note;
  int                               n_fail;
  int                               total_checks;
  int unsigned                      per;
  int unsigned                      nev;

  paired_timer paired_timer_inst (
    .clk         (clk),
    .srst        (srst),
    .ce          (ce),
    .idle        (idle),
    .sleep       (sleep),
    .ctrl        (ctrl),
    .period      (period),
    .flag_clr    (flag_clr),
    .ext_clk_pin (ext_clk_pin),
    .gate_pin    (gate_pin),
    .cnt_o       (cnt_o),
    .flag_o      (flag_o),
    .dma_trig    (dma_trig),
    .adc_trig    (adc_trig),
    .tb_cnt      (tb_cnt),
    .tb_match    (tb_match)
  );

  // Clock at 4 ns
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Reset with all controls cleared
  task rst;
    srst        = 1'b1;
    ce          = 1'b1;
    idle        = 1'b0;
    sleep       = 1'b0;
    ctrl        = '0;
    period      = '0;
    flag_clr    = 4'h0;
    ext_clk_pin = 4'h0;
    gate_pin    = 4'h0;
    cyc(2);
    srst = 1'b0;
  endtask : rst

  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // Event monitor: oldest note against each trigger pulse
  always @(negedge clk)
  begin
    if (srst === 1'b0 && (dma_trig !== 4'h0 || adc_trig !== 1'b0))
    begin
      exp_note = (notes.size() > 0) ? notes.pop_front() : 5'h00;
      `CHK("events", exp_note, {adc_trig, dma_trig})
    end
  end

  // Watchdog
  initial
  begin
    cyc(80000);
    n_fail++;
    $display("[FAIL] watchdog expected done seen timeout");
    complete_run();
  end

  initial
  begin
    n_fail       = 0;
    total_checks = 0;
    void'($urandom(32'hD47DEE1D));
    rst();
    // Timers three and five, 16-bit, random period
    per                = $urandom_range(2, 20);
    period[1]          = per[15:0];
    period[3]          = per[15:0];
    ctrl[1].on         = 1'b1;
    ctrl[3].on         = 1'b1;
    notes.push_back(5'h1A);
    cyc(per);
    `CHK("cnt3", per[15:0], cnt_o[1])
    `CHK("flag3 early", 1'b0, flag_o[1])
    cyc(1);
    `CHK("cnt3 wrap", 16'h0000, cnt_o[1])
    `CHK("flags", 4'hA, flag_o)
    `CHK("tb_match", 2'b10, tb_match)
    ctrl   = '0;
    flag_clr = 4'h2;
    cyc(1);
    flag_clr = 4'h0;
    `CHK("flag3 clr", 4'h8, flag_o)
    $display("test sixteen_bit done");
    // Timer two counts external edges
    rst();
    period[0]         = 16'hFFFF;
    ctrl[0].on        = 1'b1;
    ctrl[0].ext_src   = 1'b1;
    nev               = $urandom_range(3, 8);
    repeat (nev)
    begin
      ext_clk_pin = 4'hF;
      cyc(4);
      ext_clk_pin = 4'h0;
      cyc(4);
    end
    `CHK("ext count", nev[15:0], cnt_o[0])
    $display("test ext_count done");
    // Idle stop and sleep run
    rst();
    period[2]          = 16'hFFFF;
    period[3]          = 16'hFFFF;
    ctrl[2].on         = 1'b1;
    ctrl[2].stop_idle  = 1'b1;
    idle               = 1'b1;
    cyc(10);
    `CHK("idle hold", 16'h0000, cnt_o[2])
    idle               = 1'b0;
    sleep              = 1'b1;
    ctrl[2].run_sleep  = 1'b1;
    ctrl[3].on         = 1'b1;
    cyc(10);
    `CHK("sleep run", 16'h000A, cnt_o[2])
    `CHK("sleep stop", 16'h0000, cnt_o[3])
    $display("test power done");
    // Pair B as one gated 32-bit timer at /8, frozen for five cycles
    rst();
    period[2]    = 16'h0003;
    ctrl[2].on   = 1'b1;
    ctrl[2].t32  = 1'b1;
    ctrl[2].gate = 1'b1;
    ctrl[2].psc  = paired_timer_pkg::PSC_8;
    gate_pin     = 4'h4;
    notes.push_back(5'h08);
    cyc(20);
    ce = 1'b0;
    cyc(5);
    `CHK("freeze", 32'h0000_0002, {cnt_o[3], cnt_o[2]})
    ce = 1'b1;
    cyc(16);
    `CHK("pair b wrap", 32'h0000_0000, {cnt_o[3], cnt_o[2]})
    `CHK("pair b flag", 4'h8, flag_o)
    flag_clr = 4'h8;
    gate_pin = 4'h0;
    cyc(1);
    flag_clr = 4'h0;
    `CHK("pair b clr", 4'h0, flag_o)
    cyc(3);
    `CHK("gate fall", 4'h8, flag_o)
    $display("test pair_b done");
    // Timers two and three at the long prescaler ratios
    rst();
    period[0]   = 16'hFFFF;
    period[1]   = 16'hFFFF;
    ctrl[0].on  = 1'b1;
    ctrl[0].psc = paired_timer_pkg::PSC_256;
    ctrl[1].on  = 1'b1;
    ctrl[1].psc = paired_timer_pkg::PSC_64;
    cyc(256);
    `CHK("prescale", 32'h0004_0001, {cnt_o[1], cnt_o[0]})
    `CHK("tb_cnt", 32'h0004_0001, tb_cnt)
    $display("test prescale done");
    // Pair A as one 32-bit timer, odd control random
    rst();
    period[0]   = 16'h0001;
    period[1]   = 16'h0001;
    ctrl[0].on  = 1'b1;
    ctrl[0].t32 = 1'b1;
    ctrl[1]     = paired_timer_pkg::tmr_ctrl_s'(8'($urandom_range(0, 255)));
    gate_pin    = 4'h2;
    notes.push_back(5'h12);
    cyc(65536);
    `CHK("carry", 32'h0001_0000, {cnt_o[1], cnt_o[0]})
    cyc(2);
    `CHK("pair wrap", 32'h0000_0000, {cnt_o[1], cnt_o[0]})
    `CHK("pair flag", 4'h2, flag_o)
    $display("test thirty_two_bit done");
    cyc(2);
    `CHK("notes left", 0, notes.size())
    complete_run();
  end
endmodule : paired_timer_test
